// ---- crf_pkg.sv ----
// Shared constants and types for the continuous return carrier framer
package crf_pkg;

  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] CRF_REG_CTRL   = 4'h0;
  localparam logic [3:0] CRF_REG_EVENT  = 4'h1;
  localparam logic [3:0] CRF_REG_TXCFG  = 4'h2;
  localparam logic [3:0] CRF_REG_STATUS = 4'h3;
  localparam logic [3:0] CRF_REG_FRAME  = 4'h4;

  // CTRL field positions
  localparam int CRF_CTRL_ENH   = 0;
  localparam int CRF_CTRL_PERM  = 1;
  localparam int CRF_CTRL_CCSUP = 2;
  localparam int CRF_CTRL_FIXED = 3;
  localparam int CRF_CTRL_RANGE = 4;
  localparam int CRF_CTRL_DESC  = 5;
  localparam logic [5:0] CRF_CTRL_RESET = 6'h04;

  // EVENT field positions (write one pulses)
  localparam int CRF_EV_LOGON   = 0;
  localparam int CRF_EV_LOGOFF  = 1;
  localparam int CRF_EV_ASSIGN  = 2;
  localparam int CRF_EV_RELALL  = 3;
  localparam int CRF_EV_INIT    = 4;
  localparam int CRF_EV_FAIL    = 5;

  // Framing constants
  localparam logic [6:0] CRF_SLOT_LEN  = 7'd90;
  localparam logic [5:0] CRF_PILOT_LEN = 6'd36;
  localparam logic [4:0] CRF_PILOT_GRP = 5'd16;
  localparam logic [4:0] CRF_MODCOD_BPSK = 5'h1f;
  localparam logic [1:0] CRF_TYPE_VSF    = 2'h0;
  localparam logic [15:0] CRF_PILOT_IQ   = 16'h5a82;  // 1/sqrt2 in Q1.15

  typedef enum logic [1:0] {
    CRF_M_OFF  = 2'b00,
    CRF_M_FINE = 2'b01,
    CRF_M_CONT = 2'b10,
    CRF_M_BOTH = 2'b11
  } crf_mode_t;

  typedef enum logic [2:0] {
    CRF_MOD_BPSK  = 3'b000,
    CRF_MOD_QPSK  = 3'b001,
    CRF_MOD_8PSK  = 3'b010,
    CRF_MOD_16APSK = 3'b011,
    CRF_MOD_32APSK = 3'b100
  } crf_modn_t;

  typedef struct packed {
    logic       logon;
    logic       logoff;
    logic       assign_ok;
    logic       release_all;
    logic       init_ok;
    logic       fail;
  } crf_event_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } crf_sym_t;

  typedef struct packed {
    logic [5:0] s;
    logic [6:0] k;
    logic [2:0] stuff;
  } crf_geom_t;

endpackage

// ---- crf_mode_fsm.sv ----
// Operating-mode state machine of the terminal
`timescale 1ns/10ps
module crf_mode_fsm
  import crf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enhanced,
  input  wire logic       perm_carrier,
  input  crf_event_t      ev,
  output crf_mode_t       mode
);

  typedef struct packed {
    crf_mode_t mode;
  } crf_fsm_st_t;

  crf_fsm_st_t st_r;
  crf_fsm_st_t st_nxt;

  // Next mode from one successful process event
  always_comb begin
    st_nxt = st_r;
    // RL24: failure holds state
    if (!ev.fail) begin
      // RL1: one mode at a time
      unique case (st_r.mode)
        CRF_M_OFF: begin
          // RL2: logon to fine sync
          if (ev.logon) begin
            st_nxt.mode = CRF_M_FINE;
          // RL4: permanent carrier direct
          end else if (ev.init_ok && perm_carrier) begin
            st_nxt.mode = CRF_M_CONT;
          end
        end
        CRF_M_FINE: begin
          // RL3: logoff to standby
          if (ev.logoff) begin
            st_nxt.mode = CRF_M_OFF;
          end else if (ev.assign_ok) begin
            // RL6: basic goes continuous
            // RL8: enhanced goes combined
            st_nxt.mode = enhanced ? CRF_M_BOTH : CRF_M_CONT;
          end
        end
        CRF_M_CONT: begin
          // RL7: logon releases carrier
          if (ev.logon) begin
            st_nxt.mode = CRF_M_FINE;
          // RL5: all released to standby
          end else if (ev.release_all) begin
            st_nxt.mode = CRF_M_OFF;
          end
        end
        CRF_M_BOTH: begin
          // RL9: released drops to fine sync
          if (ev.release_all) begin
            st_nxt.mode = CRF_M_FINE;
          // RL10: logoff drops to continuous
          end else if (ev.logoff) begin
            st_nxt.mode = CRF_M_CONT;
          end
        end
      endcase
    end
  end

  // Mode register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{mode: CRF_M_OFF};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mode = st_r.mode;

endmodule

// ---- crf_bpsk_map.sv ----
// Absolute pi/2 BPSK mapper alternating the two sub-constellations
`timescale 1ns/10ps
module crf_bpsk_map
  import crf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sof,
  input  wire logic       bit_vld,
  input  wire logic       bit_in,
  output crf_sym_t        sym
);

  typedef struct packed {
    logic     phase;
    crf_sym_t sym;
  } crf_map_st_t;

  crf_map_st_t st_r;
  crf_map_st_t st_nxt;

  // Even symbols b1 on the +45 diagonal, odd b2 on the -45 diagonal
  always_comb begin
    logic ph;
    ph = 1'b0;
    st_nxt = st_r;
    // RL14: first header bit is b1
    ph = sof ? 1'b0 : st_r.phase;
    // A start with no bit beside it must still clear the phase
    st_nxt.phase = ph;
    if (bit_vld) begin
      // RL14: absolute, no differential
      st_nxt.sym.i = bit_in ? -CRF_PILOT_IQ : CRF_PILOT_IQ;
      st_nxt.sym.q = (bit_in ^ ph) ? -CRF_PILOT_IQ : CRF_PILOT_IQ;
      st_nxt.phase = ~ph;
    end
  end

  // Mapper registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Value handed on in the cycle of its bit; the framer registers it
  // beside sym_vld, so a registered copy here would lag one symbol
  assign sym = st_nxt.sym;

endmodule

// ---- crf_top.sv ----
// Continuous return carrier framer: mode control and very short framing
//
// Notes on behaviour
// RL1: exactly one of four operating modes holds at any time.
// RL2: standby moves to fine sync after a successful logon.
// RL3: fine sync moves to standby after a successful logoff.
// RL4: permanent carrier terminal goes standby to continuous on initialisation.
// RL5: continuous returns to standby once every carrier is released.
// RL6: basic terminal in fine sync with carrier assigned goes continuous.
// RL7: basic terminal in continuous that logs on goes fine sync.
// RL8: enhanced terminal in fine sync with carrier goes combined mode.
// RL9: combined mode drops to fine sync when carriers released.
// RL10: combined mode drops to continuous after logoff.
// RL11: basic sends burst or carrier; enhanced may send both.
// RL12: fixed flag or no range uses planned mode, else chosen mode.
// RL13: no adaptive coding with pi/2 BPSK at rate one quarter.
// RL14: pi/2 BPSK absolute, alternating b1/b2, header MSB as b1.
// RL15: default scrambling sequence when no mode descriptor applies.
// RL16: pi/2 BPSK puts 11111 in the header modcod field.
// RL17: very short frames use type 00 and always carry pilots.
// RL18: very short frames bypass bit interleaving.
// RL19: stuffing bits: 2 for 8PSK, 4 for 32APSK, else none.
// RL20: last slot k data symbols, rest unmodulated 1/sqrt2 pilots.
// RL21: slot counts S/k per modulation as tabulated.
// RL22: one 36-symbol pilot block per 16 slots, floor((S-1)/16).
// RL23: sign-on burst advertises continuous carrier support.
// RL24: failed attempts leave mode and transmission unchanged.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module crf_top
  import crf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        frame_start,
  input  wire logic        data_vld,
  input  wire logic        data_bit,
  output logic             data_rdy,
  output logic             sym_vld,
  output logic [15:0]      sym_i,
  output logic [15:0]      sym_q,
  output logic             sym_pilot,
  output logic             burst_tx_en,
  output logic             cont_tx_en,
  output logic             csc_cc_support,
  output logic             interleave_bypass,
  output logic             scr_default,
  output logic             acm_active,
  output logic [4:0]       hdr_modcod,
  output logic [1:0]       hdr_type,
  output logic [2:0]       stuff_bits
);

  // Modulation geometry: S, k and stuffing count
  // Illegal codes fall back to pi/2 BPSK
  function automatic crf_geom_t geom(input crf_modn_t m);
    crf_geom_t g;
    g = '{s: 6'd45, k: 7'd46, stuff: 3'd0};
    // RL21: slot table
    // RL19: stuffing per modulation
    unique case (m)
      CRF_MOD_BPSK:   g = '{s: 6'd45, k: 7'd46, stuff: 3'd0};
      CRF_MOD_QPSK:   g = '{s: 6'd22, k: 7'd68, stuff: 3'd0};
      CRF_MOD_8PSK:   g = '{s: 6'd15, k: 7'd16, stuff: 3'd2};
      CRF_MOD_16APSK: g = '{s: 6'd11, k: 7'd34, stuff: 3'd0};
      CRF_MOD_32APSK: g = '{s: 6'd9,  k: 7'd10, stuff: 3'd4};
      default:        g = '{s: 6'd45, k: 7'd46, stuff: 3'd0};
    endcase
    return g;
  endfunction

  // Framer phases; only the data phase takes bits
  // Both pilot phases run without the source
  typedef enum logic [1:0] {
    CRF_F_IDLE = 2'b00,
    CRF_F_DATA = 2'b01,
    CRF_F_FILL = 2'b10,
    CRF_F_PBLK = 2'b11
  } crf_fsm_t;

  // All framer state in one record
  // Pulse outputs default to zero each cycle,
  // so each stands for exactly one cycle
  typedef struct packed {
    logic [5:0]  ctrl;
    logic [2:0]  plan_mod;
    logic [2:0]  own_mod;
    logic        rate_q;
    logic [4:0]  plan_modcod;
    logic [4:0]  own_modcod;
    crf_fsm_t    fs;
    crf_modn_t   cur_mod;
    logic [5:0]  slot;
    logic [6:0]  pos;
    logic [3:0]  grp;
    logic [31:0] rdata;
    logic        sym_vld;
    logic [15:0] sym_i;
    logic [15:0] sym_q;
    logic        sym_pilot;
    logic        data_rdy;
    logic        burst_en;
    logic        cont_en;
    logic        scr_def;
    logic        acm;
    logic [4:0]  modcod;
    logic [2:0]  stuff;
    logic [31:0] frames;
  } crf_st_t;

  crf_st_t    st_r;
  crf_st_t    st_nxt;
  crf_event_t ev;
  crf_mode_t  mode;
  crf_sym_t   bpsk_sym;
  crf_geom_t  g;
  crf_geom_t  sel_g;
  crf_modn_t  sel_mod;
  logic       use_plan;
  logic       take_bit;
  logic       frame_go;

  // Event register: one-cycle pulses from software writes
  // A fail bit in the same write vetoes all
  always_comb begin
    ev = '0;
    if (reg_wr && reg_addr == CRF_REG_EVENT) begin
      ev.logon       = reg_wdata[CRF_EV_LOGON];
      ev.logoff      = reg_wdata[CRF_EV_LOGOFF];
      ev.assign_ok   = reg_wdata[CRF_EV_ASSIGN];
      ev.release_all = reg_wdata[CRF_EV_RELALL];
      ev.init_ok     = reg_wdata[CRF_EV_INIT];
      ev.fail        = reg_wdata[CRF_EV_FAIL];
    end
  end

  // Mode machine; flags come from CTRL
  crf_mode_fsm u_fsm (
    .clk          (clk),
    .rst          (rst),
    .enhanced     (st_r.ctrl[CRF_CTRL_ENH]),
    .perm_carrier (st_r.ctrl[CRF_CTRL_PERM]),
    .ev           (ev),
    .mode         (mode)
  );

  // A start counts only in idle with the carrier up; a stray start in
  // mid-frame must not restart the mapper phase or the counters
  assign frame_go = frame_start && (st_r.fs == CRF_F_IDLE) && st_r.cont_en;

  // Bits are taken only in the data phase
  assign take_bit = (st_r.fs == CRF_F_DATA) && data_vld;

  // Phase restarts only on an accepted start
  crf_bpsk_map u_map (
    .clk     (clk),
    .rst     (rst),
    .sof     (frame_go),
    .bit_vld (take_bit),
    .bit_in  (data_bit),
    .sym     (bpsk_sym)
  );

  // Transmission mode choice
  // Range limits are left to software
  always_comb begin
    // RL12: planned mode unless free to choose
    use_plan = st_r.ctrl[CRF_CTRL_FIXED] || !st_r.ctrl[CRF_CTRL_RANGE];
    // RL13: no adaptive choice at pi/2 BPSK rate 1/4
    if (st_r.plan_mod == CRF_MOD_BPSK && st_r.rate_q) begin
      use_plan = 1'b1;
    end
    sel_mod = crf_modn_t'(use_plan ? st_r.plan_mod : st_r.own_mod);
    // Next frame and frame in flight
    sel_g = geom(sel_mod);
    g = geom(st_r.cur_mod);
  end

  // Main next-state logic
  // Register port, flags and sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.sym_vld = 1'b0;
    st_nxt.sym_pilot = 1'b0;
    st_nxt.rdata = 32'h0000_0000;

    // Register writes
    // EVENT decoded above; others ignore writes
    if (reg_wr) begin
      unique case (reg_addr)
        CRF_REG_CTRL: st_nxt.ctrl = reg_wdata[5:0];
        CRF_REG_TXCFG: begin
          st_nxt.plan_mod    = reg_wdata[2:0];
          st_nxt.own_mod     = reg_wdata[6:4];
          st_nxt.rate_q      = reg_wdata[7];
          st_nxt.plan_modcod = reg_wdata[12:8];
          st_nxt.own_modcod  = reg_wdata[20:16];
        end
        default: ;
      endcase
    end

    // Register reads, data one cycle later
    // Unmapped and idle cycles read zero
    if (reg_rd) begin
      unique case (reg_addr)
        CRF_REG_CTRL:   st_nxt.rdata = {26'h000_0000, st_r.ctrl};
        CRF_REG_TXCFG:  st_nxt.rdata = {11'h000, st_r.own_modcod, 3'h0,
                                        st_r.plan_modcod, st_r.rate_q,
                                        st_r.own_mod, 1'b0, st_r.plan_mod};
        CRF_REG_STATUS: st_nxt.rdata = {24'h00_0000, st_r.acm,
                                        st_r.scr_def, st_r.fs,
                                        st_r.cont_en, st_r.burst_en, mode};
        CRF_REG_FRAME:  st_nxt.rdata = st_r.frames;
        default:        st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Enables lag the mode by one cycle
    // RL11: carrier and burst enables per mode
    st_nxt.burst_en = (mode == CRF_M_FINE) || (mode == CRF_M_BOTH);
    st_nxt.cont_en  = (mode == CRF_M_CONT) || (mode == CRF_M_BOTH);
    // RL15: default scrambling without descriptor
    st_nxt.scr_def = !st_r.ctrl[CRF_CTRL_DESC];
    st_nxt.acm = !use_plan;

    // Frame sequencer; holds in idle unless carrier is enabled
    unique case (st_r.fs)
      // Wait for a start; mode latched per frame
      CRF_F_IDLE: begin
        st_nxt.data_rdy = 1'b0;
        if (frame_go) begin
          st_nxt.cur_mod = sel_mod;
          // Other modcods pass through
          // RL16: modcod fixed for pi/2 BPSK
          st_nxt.modcod = (sel_mod == CRF_MOD_BPSK) ? CRF_MODCOD_BPSK :
                          (use_plan ? st_r.plan_modcod : st_r.own_modcod);
          st_nxt.stuff = sel_g.stuff;
          st_nxt.slot = 6'd0;
          st_nxt.pos = 7'd0;
          st_nxt.grp = 4'd0;
          st_nxt.fs = CRF_F_DATA;
          st_nxt.data_rdy = 1'b1;
        end
      end

      // One accepted bit per symbol
      CRF_F_DATA: begin
        if (data_vld) begin
          st_nxt.sym_vld = 1'b1;
          st_nxt.sym_i = bpsk_sym.i;
          st_nxt.sym_q = bpsk_sym.q;
          // A stalled source holds the position
          st_nxt.pos = st_r.pos + 7'd1;
          if (st_r.slot == g.s && st_r.pos == g.k - 7'd1) begin
            // RL20: rest of last slot is pilot
            st_nxt.fs = CRF_F_FILL;
            st_nxt.data_rdy = 1'b0;
          end else if (st_r.pos == CRF_SLOT_LEN - 7'd1) begin
            st_nxt.pos = 7'd0;
            st_nxt.slot = st_r.slot + 6'd1;
            st_nxt.grp = st_r.grp + 4'd1;
            // None before the short last slot
            // RL22: pilot block every 16 slots
            // RL17: pilots always present
            if (st_r.grp == 4'(CRF_PILOT_GRP - 5'd1) &&
                st_r.slot + 6'd1 < g.s) begin
              st_nxt.fs = CRF_F_PBLK;
              st_nxt.pos = 7'd0;
              st_nxt.data_rdy = 1'b0;
            end
          end
        end
      end

      // Fixed pilot block, then data again
      CRF_F_PBLK: begin
        st_nxt.sym_vld = 1'b1;
        st_nxt.sym_pilot = 1'b1;
        st_nxt.sym_i = CRF_PILOT_IQ;
        st_nxt.sym_q = CRF_PILOT_IQ;
        st_nxt.pos = st_r.pos + 7'd1;
        if (st_r.pos == 7'(CRF_PILOT_LEN) - 7'd1) begin
          st_nxt.pos = 7'd0;
          st_nxt.fs = CRF_F_DATA;
          st_nxt.data_rdy = 1'b1;
        end
      end

      // Tail of the last slot, then idle
      CRF_F_FILL: begin
        // RL20: unmodulated 1/sqrt2 fill
        st_nxt.sym_vld = 1'b1;
        st_nxt.sym_pilot = 1'b1;
        st_nxt.sym_i = CRF_PILOT_IQ;
        st_nxt.sym_q = CRF_PILOT_IQ;
        st_nxt.pos = st_r.pos + 7'd1;
        if (st_r.pos == CRF_SLOT_LEN - 7'd1) begin
          st_nxt.fs = CRF_F_IDLE;
          // Counter wraps silently
          st_nxt.frames = st_r.frames + 32'h0000_0001;
        end
      end
    endcase
  end

  // State register
  // Reset loads constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= CRF_CTRL_RESET;
      st_r.scr_def <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only very short frames are built here
  // Outputs straight from flip-flops, except the constant hdr_type
  assign reg_rdata      = st_r.rdata;
  assign data_rdy       = st_r.data_rdy;
  assign sym_vld        = st_r.sym_vld;
  assign sym_i          = st_r.sym_i;
  assign sym_q          = st_r.sym_q;
  assign sym_pilot      = st_r.sym_pilot;
  assign burst_tx_en    = st_r.burst_en;
  assign cont_tx_en     = st_r.cont_en;
  // RL23: support flag for the sign-on burst
  assign csc_cc_support = st_r.ctrl[CRF_CTRL_CCSUP];
  // RL18: interleaver bypassed whenever the continuous carrier enable is set
  assign interleave_bypass = st_r.cont_en;
  assign scr_default    = st_r.scr_def;
  assign acm_active     = st_r.acm;
  // Header fields follow the last start
  assign hdr_modcod     = st_r.modcod;
  // RL17: very short frame type
  assign hdr_type       = CRF_TYPE_VSF;
  assign stuff_bits     = st_r.stuff;

endmodule

// ---- crf_top_props.sv ----
// Concurrent checks on the ports of the continuous carrier framer
`timescale 1ns/10ps
module crf_top_props
  import crf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        frame_start,
  input wire logic        data_vld,
  input wire logic        data_rdy,
  input wire logic        sym_vld,
  input wire logic [15:0] sym_i,
  input wire logic [15:0] sym_q,
  input wire logic        sym_pilot,
  input wire logic        cont_tx_en,
  input wire logic        csc_cc_support,
  input wire logic        interleave_bypass,
  input wire logic        scr_default,
  input wire logic [1:0]  hdr_type,
  input wire logic [2:0]  stuff_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Event register write, the only cause of a mode change
  logic ev_wr;
  assign ev_wr = reg_wr && (reg_addr == CRF_REG_EVENT);

  // One bit taken in, then one data symbol out
  sequence take_bit_s;
    data_vld && data_rdy;
  endsequence
  sequence data_sym_s;
    sym_vld && !sym_pilot;
  endsequence

  type_zero_a: assert property (hdr_type == CRF_TYPE_VSF)
    else $error("header type not zero");
  bypass_cont_a: assert property (interleave_bypass == cont_tx_en)
    else $error("interleave bypass differs from carrier enable");
  stuff_set_a: assert property (stuff_bits inside {3'h0, 3'h2, 3'h4})
    else $error("stuffing count illegal");
  pilot_value_a: assert property (sym_vld && sym_pilot |->
    sym_i == CRF_PILOT_IQ && sym_q == CRF_PILOT_IQ)
    else $error("pilot symbol not unmodulated");
  bit_symbol_a: assert property (take_bit_s |=> data_sym_s)
    else $error("accepted bit gave no data symbol");
  start_cause_a: assert property ($rose(data_rdy) |->
    $past(frame_start) || sym_pilot)
    else $error("frame opened without start");
  idle_nocont_a: assert property (!cont_tx_en |-> !data_rdy && !sym_vld)
    else $error("framing without continuous carrier");
  mode_cause_a: assert property ($changed(cont_tx_en) |->
    $past(ev_wr, 1) || $past(ev_wr, 2) || $past(ev_wr, 3))
    else $error("carrier enable changed without event");
  reset_vals_a: assert property ($fell(rst) |->
    scr_default && csc_cc_support)
    else $error("reset values of flags wrong");
endmodule

bind crf_top crf_top_props u_props (.clk, .rst, .reg_addr, .reg_wr,
  .frame_start, .data_vld, .data_rdy, .sym_vld, .sym_i, .sym_q, .sym_pilot,
  .cont_tx_en, .csc_cc_support, .interleave_bypass, .scr_default,
  .hdr_type, .stuff_bits);

// ---- crf_src_model.sv ----
// Bit source standing in for the traffic side of the framer
`timescale 1ns/10ps
module crf_src_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic data_rdy,
  input  wire logic stall,
  output logic      data_vld,
  output logic      data_bit
);
  logic [6:0] lfsr_r;
  // Offer a fresh bit whenever the framer is ready and no stall is asked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_r   <= 7'h5b;
      data_vld <= 1'b0;
      data_bit <= 1'b0;
    end else if (data_vld && !data_rdy) begin
      // Offered bit not taken yet: keep offering it
      data_bit <= data_bit;
    end else if (data_rdy && !stall) begin
      lfsr_r   <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
      data_vld <= 1'b1;
      data_bit <= lfsr_r[6];
    end else begin
      // Idle line flips so a stale bit never looks valid
      data_vld <= 1'b0;
      data_bit <= ~data_bit;
    end
  end
endmodule

// ---- crf_top_tb.sv ----
// Self-checking bench for the continuous carrier framer
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module crf_top_tb
  import crf_pkg::*;
;
  localparam logic [5:0] ev_on = 6'h01, ev_off = 6'h02, ev_asn = 6'h04;
  localparam logic [5:0] ev_rel = 6'h08, ev_ini = 6'h10, ev_bad = 6'h20;
  int          s_tab [5] = '{45, 22, 15, 11, 9};
  int          k_tab [5] = '{46, 68, 16, 34, 10};
  int          st_tab [5] = '{0, 0, 2, 0, 4};
  logic        clk, rst, reg_wr, reg_rd, frame_start, stall;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic        data_vld, data_bit, data_rdy, sym_vld, sym_pilot;
  logic [15:0] sym_i, sym_q, ex;
  logic        burst_tx_en, cont_tx_en, csc_cc_support, interleave_bypass;
  logic        scr_default, acm_active;
  logic [4:0]  hdr_modcod;
  logic [1:0]  hdr_type;
  logic [2:0]  stuff_bits;
  int          n_mismatch, total_checks;

  crf_top DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .frame_start, .data_vld, .data_bit, .data_rdy, .sym_vld,
    .sym_i, .sym_q, .sym_pilot, .burst_tx_en, .cont_tx_en, .csc_cc_support,
    .interleave_bypass, .scr_default, .acm_active, .hdr_modcod, .hdr_type,
    .stuff_bits);
  crf_src_model u_src (.clk, .rst, .data_rdy, .stall, .data_vld, .data_bit);

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Write, then let the registered outputs settle
  task automatic cfg(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic [5:0] e, input logic [1:0] m,
                      input logic b, input logic c);
    wr(CRF_REG_EVENT, {26'h0, e});
    rd(CRF_REG_STATUS);
    `CHK("mode", m, v[1:0])
    @(posedge clk);
    #1;
    `CHK("burst_tx_en", b, burst_tx_en)
    `CHK("cont_tx_en", c, cont_tx_en)
  endtask
  task automatic kick;
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
  endtask

  task automatic t_reset;
    rd(CRF_REG_CTRL);
    `CHK("ctrl", 32'h0000_0004, v)
    `CHK("csc_cc_support", 1'b1, csc_cc_support)
    `CHK("scr_default", 1'b1, scr_default)
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf);
    `CHK("unmapped", 32'h0000_0000, v)
    rd(CRF_REG_CTRL);
    `CHK("ctrl_kept", 32'h0000_0004, v)
    kick();
    repeat (2) @(posedge clk);
    #1;
    `CHK("data_rdy_off", 1'b0, data_rdy)
    $display("test reset done");
  endtask
  task automatic t_basic;
    cfg(CRF_REG_CTRL, 32'h0000_0004);
    step(ev_on | ev_bad, 2'h0, 1'b0, 1'b0);
    step(ev_on, 2'h1, 1'b1, 1'b0);
    step(ev_asn, 2'h2, 1'b0, 1'b1);
    step(ev_on, 2'h1, 1'b1, 1'b0);
    step(ev_off, 2'h0, 1'b0, 1'b0);
    $display("test basic done");
  endtask
  task automatic t_enh;
    cfg(CRF_REG_CTRL, 32'h0000_0005);
    step(ev_on, 2'h1, 1'b1, 1'b0);
    step(ev_asn, 2'h3, 1'b1, 1'b1);
    step(ev_rel, 2'h1, 1'b1, 1'b0);
    step(ev_asn, 2'h3, 1'b1, 1'b1);
    step(ev_off, 2'h2, 1'b0, 1'b1);
    step(ev_rel | ev_bad, 2'h2, 1'b0, 1'b1);
    step(ev_rel, 2'h0, 1'b0, 1'b0);
    $display("test enhanced done");
  endtask
  task automatic t_acm;
    cfg(CRF_REG_CTRL, 32'h0000_001c);
    `CHK("acm_fixed", 1'b0, acm_active)
    `CHK("scr_nodesc", 1'b1, scr_default)
    cfg(CRF_REG_TXCFG, 32'h0000_0001);
    cfg(CRF_REG_CTRL, 32'h0000_0034);
    `CHK("acm_free", 1'b1, acm_active)
    `CHK("scr_desc", 1'b0, scr_default)
    cfg(CRF_REG_TXCFG, 32'h0000_0080);
    `CHK("acm_bpsk_q", 1'b0, acm_active)
    cfg(CRF_REG_CTRL, 32'h0000_0024);
    `CHK("acm_norange", 1'b0, acm_active)
    $display("test acm done");
  endtask
  // One very short frame, a stray start in mid-frame, stalls from the source
  task automatic t_frame(input int m);
    int s, k, nd, np, nf, n, q;
    s = s_tab[m];
    k = k_tab[m];
    nd = 0;
    np = 0;
    nf = 0;
    n = 0;
    q = 0;
    cfg(CRF_REG_TXCFG, m);
    kick();
    while (q < 20 && n < 8000) begin
      @(posedge clk);
      stall <= (n % 7 == 3);
      frame_start <= (n == 50);
      #1;
      n++;
      if (sym_vld && !sym_pilot) begin
        ex = nd[0] ? -sym_q : sym_q;
        `CHK("sym_i", ex, sym_i)
        if (nd == 0) `CHK("bypass", 1'b1, interleave_bypass)
        if (nd == 0 && m == 0) `CHK("modcod", 5'h1f, hdr_modcod)
        if (nd == 0) `CHK("hdr_type", 2'h0, hdr_type)
        nd++;
        nf = 0;
      end
      if (sym_vld && sym_pilot) begin
        np++;
        nf++;
      end
      q = (sym_vld || data_rdy) ? 0 : q + 1;
    end
    `CHK("data_syms", 90 * s + k, nd)
    `CHK("fill_pilots", 90 - k, nf)
    `CHK("all_pilots", 36 * ((s - 1) / 16) + 90 - k, np)
    `CHK("stuff_bits", st_tab[m], stuff_bits)
    $display("test frame %0d done", m);
  endtask
  task automatic t_frames;
    cfg(CRF_REG_CTRL, 32'h0000_000e);
    step(ev_ini, 2'h2, 1'b0, 1'b1);
    for (int m = 0; m < 5; m++) t_frame(m);
    rd(CRF_REG_FRAME);
    `CHK("frame_count", 32'h0000_0005, v)
    step(ev_rel, 2'h0, 1'b0, 1'b0);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    frame_start = 1'b0;
    stall = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_enh();
    t_acm();
    t_frames();
    final_report();
  end
endmodule
